// ===== wcp_pkg.sv
// Purpose: Shared constants and types for the waveform calibration and power block
// Assumes: 40 MHz system clock, seven channels, 24-bit samples
// Notes:   Channel index 0..6 is IA, IB, IC, IN, VA, VB, VC throughout
package wcp_pkg;

    // ----------------------------------------------------------------
    // Sizes and timing
    // ----------------------------------------------------------------
    localparam int NCH = 7;
    localparam int NPH = 3;
    localparam int CLK_HZ = 40_000_000;
    localparam int SAMPLE_HZ = 15_600;
    localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    localparam int SAMPLE_NS = 1_000_000_000 / SAMPLE_HZ;
    localparam int TRIM_STEP_NS = 250;
    localparam int TRIM_STEP_ALT_NS = 280;
    localparam int Q16_ONE = 65_536;
    localparam int HPF_SHIFT = 8;
    localparam int LPF_SHIFT = 4;
    localparam int PWR_SHIFT = 6;
    localparam int PROD_LSB = 23;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [6:0][7:0] WAVE_ADDR = {8'h0a, 8'h09, 8'h08, 8'h05, 8'h02, 8'h03, 8'h04};
    localparam logic [6:0][7:0] PHCAL_ADDR = {8'h69, 8'h68, 8'h67, 8'h90, 8'h66, 8'h65, 8'h64};
    localparam logic [6:0][7:0] GAIN_ADDR = {8'ha9, 8'ha8, 8'ha7, 8'ha4, 8'ha1, 8'ha2, 8'ha3};
    localparam logic [6:0][7:0] OFS_ADDR = {8'hb4, 8'hb3, 8'hb2, 8'haf, 8'hac, 8'had, 8'hae};
    localparam logic [2:0][7:0] WATT_ADDR = {8'h24, 8'h23, 8'h22};
    localparam logic [7:0] WATT_SUM_ADDR = 8'h25;
    localparam logic [7:0] SEG_LO_ADDR = 8'h62;
    localparam logic [7:0] SEG_HI_ADDR = 8'h63;
    localparam logic [7:0] CFG1_ADDR = 8'h96;
    localparam logic [7:0] CFG3_ADDR = 8'h98;

    localparam logic [23:0] SEG_LO_RST = 24'h01_0000;
    localparam logic [23:0] SEG_HI_RST = 24'h20_0000;

    // Field positions
    localparam int LEAK_SEL_BIT = 23;
    localparam int WAVE_FUND_BIT = 0;
    localparam int SUM_ALG_BIT = 8;
    localparam int PWR_FUND_BIT = 0;
    localparam int SEG_W = 8;
    localparam int SEG_EN_BIT = 7;
    localparam int CODE_LEAK_BIT = 3;
    localparam int NEUTRAL_CH = 3;
    localparam int FIRST_VOLT_CH = 4;

    // Phase owning each channel: 0 A, 1 B, 2 C, 3 neutral
    localparam logic [6:0][1:0] CH_PHASE = {2'h2, 2'h1, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0};

    // ----------------------------------------------------------------
    // Serial port framing
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_READ = 8'h35;
    localparam logic [7:0] OP_WRITE = 8'hca;
    localparam logic [5:0] CMD_END = 6'h08;
    localparam logic [5:0] ADDR_END = 6'h10;
    localparam logic [5:0] WORD_END = 6'h28;

    typedef enum logic {ST_TAKE, ST_CALC} wcp_phase_t;

endpackage

// ===== wcp_top.sv
// Purpose: Seven-channel sample correction, waveform registers and phase power
// Assumes: All pins synchronous to CLK_SYS; serial clock well below CLK_SYS / 4
// Notes:   Serial mode 0, MSB first: command byte, address byte, 24-bit words
//
// What this block does
// - Low segment uses bits 7:0, enable 7
// - Trim step 250 ns, about 0.0045 degree
// - Neutral step parameter, 250 or 280 ns
// - Middle segment uses bits 15:8, enable 15
// - Top segment uses bits 23:16, enable 23
// - Two segment points, defaults 0x010000, 0x200000
// - Seven signed offset trims, reset zero
// - Seven signed gain trims, reset zero
// - Gain scales by one plus trim over 2^16
// - Waveform registers update at 15.6 ksps
// - Waveform registers hold 24-bit signed samples
// - Seven waveform channels: IA IB IC IN VA VB VC
// - Back-to-back waveform reads served consecutively
// - Full wave via high-pass, fundamental via low-pass
// - Config one bit 23 selects leakage waveform
// - Power: multiply, filter, average, sum phases
// - Per-phase 24-bit power, full or fundamental
// - Config three bit 8 picks absolute or algebraic
`timescale 1ns/1ps

// --------------------------------------------------------------------
// Sample FIFO
// --------------------------------------------------------------------
module wcp_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
        $error("FIFO depth must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
        logic ready;
    } wcp_fifo_state_t;

    wcp_fifo_state_t q;
    wcp_fifo_state_t next_q;
    logic push;
    logic pop;

    assign out_valid = (q.wr != q.rd);
    assign out_data = q.mem[q.rd[AW-1:0]];
    assign in_ready = q.ready;
    assign push = in_valid && q.ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_q = q;
        if (push) begin
            next_q.mem[q.wr[AW-1:0]] = in_data;
            next_q.wr = q.wr + 1'b1;
        end
        if (pop) begin
            next_q.rd = q.rd + 1'b1;
        end
        // Registered ready keeps the filling side off a combinational path
        next_q.ready = ((next_q.wr - next_q.rd) != (AW + 1)'(DEPTH));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.ready <= 1'b1;
        end else begin
            q <= next_q;
        end
    end
endmodule

// --------------------------------------------------------------------
// Correction path, power and register file
// --------------------------------------------------------------------
module wcp_top
    import wcp_pkg::*;
#(
    parameter int STEP_NS = TRIM_STEP_NS,
    parameter int NEUTRAL_STEP_NS = TRIM_STEP_NS,
    parameter int FIFO_DEPTH = 8,
    parameter int SAMPLE_CYCLES = SAMPLE_DIV
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic SPI_SCLK,
    input wire logic SPI_CS_N,
    input wire logic SPI_MOSI,
    output logic SPI_MISO,
    input wire logic SAMPLE_VALID,
    output logic SAMPLE_READY,
    input wire logic [3:0] SAMPLE_CODE,
    input wire logic [23:0] SAMPLE_DATA,
    input wire logic [23:0] RMS_A,
    input wire logic [23:0] RMS_B,
    input wire logic [23:0] RMS_C,
    input wire logic [23:0] RMS_N
);
    localparam int DIV_W = $clog2(SAMPLE_CYCLES);
    // Interpolation weight of one trim step, as a fraction of a sample period
    localparam logic signed [10:0] STEP_Q16 = 11'(STEP_NS * Q16_ONE / SAMPLE_NS);
    localparam logic signed [10:0] NSTEP_Q16 = 11'(NEUTRAL_STEP_NS * Q16_ONE / SAMPLE_NS);

    if (SAMPLE_CYCLES < 4 || STEP_NS < 1 || NEUTRAL_STEP_NS < 1
        || STEP_NS * Q16_ONE / SAMPLE_NS > 1023
        || NEUTRAL_STEP_NS * Q16_ONE / SAMPLE_NS > 1023) begin : g_param_check
        $error("Sample period or trim step out of range");
    end

    typedef struct packed {
        wcp_phase_t st;
        logic [3:0] code;
        logic [23:0] data;
        logic [DIV_W-1:0] div;
        logic [6:0][23:0] prev;
        logic [6:0][23:0] dc;
        logic [6:0][23:0] lp;
        logic [6:0][23:0] full;
        logic [6:0][23:0] fund;
        logic [6:0][23:0] wave;
        logic [6:0][23:0] phcal;
        logic [6:0][15:0] chos;
        logic [6:0][15:0] chgn;
        logic [23:0] seg_lo;
        logic [23:0] seg_hi;
        logic [23:0] cfg1;
        logic [23:0] cfg3;
        logic [2:0][23:0] pwr;
        logic [23:0] wsum;
        logic sclk_q;
        logic [5:0] cnt;
        logic [7:0] cmd;
        logic [7:0] addr;
        logic [23:0] rx;
        logic [23:0] tx;
        logic miso;
    } wcp_state_t;

    wcp_state_t q;
    wcp_state_t next_q;
    logic fifo_valid;
    logic [27:0] fifo_data;

    wcp_fifo #(.WIDTH(28), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLK_SYS),
        .rst(RST),
        .in_valid(SAMPLE_VALID),
        .in_ready(SAMPLE_READY),
        .in_data({SAMPLE_CODE, SAMPLE_DATA}),
        .out_valid(fifo_valid),
        .out_ready(q.st == ST_TAKE),
        .out_data(fifo_data)
    );

    assign SPI_MISO = q.miso;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [23:0] sat24(input logic signed [47:0] v);
        if (v > 48'sh00_0000_7f_ffff) begin
            sat24 = 24'h7f_ffff;
        end else if (v < -48'sh00_0000_80_0000) begin
            sat24 = 24'h80_0000;
        end else begin
            sat24 = v[23:0];
        end
    endfunction

    function automatic logic [23:0] reg_read(input wcp_state_t s, input logic [7:0] a);
        reg_read = '0;
        for (int c = 0; c < NCH; c++) begin
            if (a == WAVE_ADDR[c]) begin
                reg_read = s.wave[c];
            end
            if (a == PHCAL_ADDR[c]) begin
                reg_read = s.phcal[c];
            end
            if (a == GAIN_ADDR[c]) begin
                reg_read = {8'h00, s.chgn[c]};
            end
            if (a == OFS_ADDR[c]) begin
                reg_read = {8'h00, s.chos[c]};
            end
        end
        for (int p = 0; p < NPH; p++) begin
            if (a == WATT_ADDR[p]) begin
                reg_read = s.pwr[p];
            end
        end
        if (a == WATT_SUM_ADDR) begin
            reg_read = s.wsum;
        end
        if (a == SEG_LO_ADDR) begin
            reg_read = s.seg_lo;
        end
        if (a == SEG_HI_ADDR) begin
            reg_read = s.seg_hi;
        end
        if (a == CFG1_ADDR) begin
            reg_read = s.cfg1;
        end
        if (a == CFG3_ADDR) begin
            reg_read = s.cfg3;
        end
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0] ch;
        logic leak_sel;
        logic use_word;
        logic [23:0] rms;
        logic [7:0] seg;
        logic signed [25:0] ofs;
        logic signed [41:0] gprod;
        logic signed [27:0] gsum;
        logic [23:0] corr;
        logic signed [24:0] diff;
        logic signed [47:0] dprod;
        logic signed [24:0] shifted;
        logic [23:0] ph;
        logic signed [24:0] hp;
        logic [23:0] full;
        logic signed [24:0] lpd;
        logic signed [47:0] prod;
        logic signed [23:0] pin;
        logic signed [47:0] total;
        logic rise;
        logic fall;
        logic [7:0] new_addr;
        logic [23:0] word;
        logic [5:0] idx;
        ch = '0;
        leak_sel = 1'b0;
        use_word = 1'b0;
        rms = '0;
        seg = '0;
        ofs = '0;
        gprod = '0;
        gsum = '0;
        corr = '0;
        diff = '0;
        dprod = '0;
        shifted = '0;
        ph = '0;
        hp = '0;
        full = '0;
        lpd = '0;
        prod = '0;
        pin = '0;
        total = '0;
        new_addr = '0;
        word = '0;
        idx = '0;
        rise = SPI_SCLK && !q.sclk_q;
        fall = !SPI_SCLK && q.sclk_q;
        next_q = q;
        next_q.sclk_q = SPI_SCLK;

        // ------------------------------------------------------------
        // Sample correction: two cycles per word so the FIFO can fill
        // ------------------------------------------------------------
        unique case (q.st)
            ST_TAKE: begin
                if (fifo_valid) begin
                    next_q.code = fifo_data[27:24];
                    next_q.data = fifo_data[23:0];
                    next_q.st = ST_CALC;
                end
            end
            ST_CALC: begin
                next_q.st = ST_TAKE;
                ch = q.code[2:0];
                leak_sel = q.cfg1[LEAK_SEL_BIT] && (int'(ch) < FIRST_VOLT_CH);
                // Leakage words replace the current words of the same channel
                use_word = (int'(ch) < NCH) && (q.code[CODE_LEAK_BIT] == leak_sel);
                if (use_word) begin
                    unique case (CH_PHASE[ch])
                        2'h0: rms = RMS_A;
                        2'h1: rms = RMS_B;
                        2'h2: rms = RMS_C;
                        default: rms = RMS_N;
                    endcase
                    // A concatenation is unsigned, so sign it before it is widened
                    ofs = 26'($signed(q.data)) + 26'($signed({q.chos[ch], 1'b0}));
                    gprod = ofs * $signed(q.chgn[ch]);
                    gsum = 28'(ofs) + 28'(gprod >>> 16);
                    corr = sat24(48'(gsum));
                    if (rms < q.seg_lo) begin
                        seg = q.phcal[ch][SEG_W-1:0];
                    end else if (rms < q.seg_hi) begin
                        seg = q.phcal[ch][2*SEG_W-1:SEG_W];
                    end else begin
                        seg = q.phcal[ch][3*SEG_W-1:2*SEG_W];
                    end
                    // Fractional delay by linear interpolation toward the last sample
                    diff = 25'($signed(corr)) - 25'($signed(q.prev[ch]));
                    // Widen every factor first so the product is not cut to 25 bits
                    dprod = 48'(diff) * 48'($signed(seg[SEG_EN_BIT-1:0]))
                        * 48'((int'(ch) == NEUTRAL_CH) ? NSTEP_Q16 : STEP_Q16);
                    shifted = 25'(dprod >>> 16);
                    if (seg[SEG_EN_BIT]) begin
                        ph = sat24(48'($signed(corr)) - 48'(shifted));
                    end else begin
                        ph = corr;
                    end
                    next_q.prev[ch] = corr;
                    hp = 25'($signed(ph)) - 25'($signed(q.dc[ch]));
                    next_q.dc[ch] = q.dc[ch] + 24'(hp >>> HPF_SHIFT);
                    full = sat24(48'(hp));
                    next_q.full[ch] = full;
                    lpd = 25'($signed(full)) - 25'($signed(q.lp[ch]));
                    next_q.lp[ch] = q.lp[ch] + 24'(lpd >>> LPF_SHIFT);
                    next_q.fund[ch] = next_q.lp[ch];
                end
            end
        endcase

        // ------------------------------------------------------------
        // Sample-rate tick: publish waveforms, update phase power
        // ------------------------------------------------------------
        if (q.div == DIV_W'(SAMPLE_CYCLES - 1)) begin
            next_q.div = '0;
            for (int c = 0; c < NCH; c++) begin
                next_q.wave[c] = q.cfg1[WAVE_FUND_BIT] ? q.fund[c] : q.full[c];
            end
            total = '0;
            for (int p = 0; p < NPH; p++) begin
                if (q.cfg3[PWR_FUND_BIT]) begin
                    prod = $signed(q.fund[p]) * $signed(q.fund[p + FIRST_VOLT_CH]);
                end else begin
                    prod = $signed(q.full[p]) * $signed(q.full[p + FIRST_VOLT_CH]);
                end
                pin = prod[PROD_LSB+23:PROD_LSB];
                // Low-pass doubles as the averaging stage
                lpd = 25'(pin) - 25'($signed(q.pwr[p]));
                next_q.pwr[p] = q.pwr[p] + 24'(lpd >>> PWR_SHIFT);
                if (q.cfg3[SUM_ALG_BIT] || !q.pwr[p][23]) begin
                    total = total + 48'($signed(q.pwr[p]));
                end else begin
                    total = total - 48'($signed(q.pwr[p]));
                end
            end
            next_q.wsum = sat24(total);
        end else begin
            next_q.div = q.div + 1'b1;
        end

        // ------------------------------------------------------------
        // Serial register port
        // ------------------------------------------------------------
        if (SPI_CS_N) begin
            next_q.cnt = '0;
        end else if (rise) begin
            next_q.cnt = q.cnt + 1'b1;
            if (q.cnt < CMD_END) begin
                next_q.cmd = {q.cmd[6:0], SPI_MOSI};
            end else if (q.cnt < ADDR_END) begin
                new_addr = {q.addr[6:0], SPI_MOSI};
                next_q.addr = new_addr;
                if (q.cnt == ADDR_END - 6'h01) begin
                    next_q.tx = reg_read(q, new_addr);
                end
            end else begin
                word = {q.rx[22:0], SPI_MOSI};
                next_q.rx = word;
                if (q.cnt == WORD_END - 6'h01) begin
                    if (q.cmd == OP_WRITE) begin
                        for (int c = 0; c < NCH; c++) begin
                            if (q.addr == PHCAL_ADDR[c]) begin
                                next_q.phcal[c] = word;
                            end
                            if (q.addr == GAIN_ADDR[c]) begin
                                next_q.chgn[c] = word[15:0];
                            end
                            if (q.addr == OFS_ADDR[c]) begin
                                next_q.chos[c] = word[15:0];
                            end
                        end
                        if (q.addr == SEG_LO_ADDR) begin
                            next_q.seg_lo = word;
                        end
                        if (q.addr == SEG_HI_ADDR) begin
                            next_q.seg_hi = word;
                        end
                        if (q.addr == CFG1_ADDR) begin
                            next_q.cfg1 = word;
                        end
                        if (q.addr == CFG3_ADDR) begin
                            next_q.cfg3 = word;
                        end
                    end
                    // Burst: next address follows without a new header
                    next_q.addr = q.addr + 8'h01;
                    next_q.cnt = ADDR_END;
                    next_q.tx = reg_read(q, q.addr + 8'h01);
                end
            end
        end else if (fall && q.cnt >= ADDR_END) begin
            idx = WORD_END - 6'h01 - q.cnt;
            next_q.miso = q.tx[idx[4:0]];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            q <= '0;
            q.seg_lo <= SEG_LO_RST;
            q.seg_hi <= SEG_HI_RST;
        end else begin
            q <= next_q;
        end
    end
endmodule

// ===== wcp_top_properties.sv
// Purpose: Port checker for wcp_top
// Assumes: Host keeps SCLK low or high for at least 4 clocks
// Notes:   FIFO counts assume a drain of one word per two cycles
`timescale 1ns/1ps
module wcp_top_properties #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic SPI_SCLK,
    input wire logic SPI_CS_N,
    input wire logic SPI_MISO,
    input wire logic SAMPLE_VALID,
    input wire logic SAMPLE_READY
);
    typedef struct packed {
        logic [7:0] run;
        logic [7:0] taken;
        logic [4:0] idle;
    } wcp_chk_t;
    wcp_chk_t st, next_st;
    logic take;
    assign take = SAMPLE_VALID && SAMPLE_READY;
    // Taken resets only after a long idle, when the queue must be empty
    always_comb begin
        next_st = st;
        next_st.run = take ? st.run + {7'd0, st.run != 8'hff} : 8'h00;
        next_st.taken = st.taken + {7'd0, take && st.taken != 8'hff};
        next_st.idle = take ? 5'd0 : st.idle + {4'd0, st.idle != 5'd24};
        if (!take && st.idle == 5'd24) begin
            next_st.taken = 8'h00;
        end
    end
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    reset_ready_a: assert property (disable iff (1'b0) RST |=> SAMPLE_READY)
        else $error("ready low after reset");
    reset_miso_a: assert property (disable iff (1'b0) RST |=> !SPI_MISO)
        else $error("miso high after reset");
    miso_change_a: assert property (!$stable(SPI_MISO) && !SPI_CS_N |-> !SPI_SCLK)
        else $error("miso moved while sclk high");
    miso_hold_a: assert property (SPI_SCLK && $past(SPI_SCLK) |-> $stable(SPI_MISO))
        else $error("miso unstable in high phase");
    ready_fall_a: assert property ($fell(SAMPLE_READY) |-> $past(SAMPLE_VALID))
        else $error("ready fell without a take");
    ready_back_a: assert property ($fell(SAMPLE_READY) |-> ##[1:6] SAMPLE_READY)
        else $error("ready stayed low");
    fill_bound_a: assert property (st.run <= 8'd24)
        else $error("queue never filled");
    early_full_a: assert property ($fell(SAMPLE_READY) |-> st.taken >= FIFO_DEPTH)
        else $error("ready fell before queue full");
    cover property ($fell(SAMPLE_READY));
    cover property ($fell(SPI_CS_N));
    cover property (SPI_MISO && !SPI_CS_N);
endmodule
bind wcp_top wcp_top_properties #(.FIFO_DEPTH(FIFO_DEPTH)) i_props (.CLK_SYS(CLK_SYS),
    .RST(RST), .SPI_SCLK(SPI_SCLK), .SPI_CS_N(SPI_CS_N), .SPI_MISO(SPI_MISO),
    .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_READY(SAMPLE_READY));

// ===== wcp_host.sv
// Purpose: Host serial master model
// Assumes: Mode 0, MSB first, SCLK at CLK_SYS / 8
// Notes:   Frames are started by the bench through frame()
`timescale 1ns/1ps
module wcp_host (
    input wire logic clk,
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        mosi = b;
        repeat (4) @(negedge clk);
        sclk = 1'b1;
        r = miso;
        repeat (4) @(negedge clk);
        sclk = 1'b0;
    endtask
    task automatic frame(input logic [7:0] cmd, input logic [7:0] adr, input int n,
                         inout logic [23:0] w [4]);
        logic r;
        logic [15:0] hd;
        hd = {cmd, adr};
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) bit_io(hd[i], r);
        // Burst: one word after another in the same frame
        for (int k = 0; k < n; k++) begin
            for (int i = 23; i >= 0; i--) begin
                bit_io(w[k][i], r);
                w[k][i] = r;
            end
        end
        repeat (2) @(negedge clk);
        cs_n = 1'b1;
        // Released data line must not look like a held bit
        mosi = ~mosi;
        repeat (4) @(negedge clk);
    endtask
endmodule

// ===== tb_wcp_top.sv
// Purpose: Self-checking bench for wcp_top
// Assumes: Short sample tick of 16 cycles
// Notes:   Wave magnitude checks use a tolerance since the full wave passes a high-pass
`timescale 1ns/1ps
module tb_wcp_top
    import wcp_pkg::*;
;
    localparam logic [15:0] GAINS [3] = '{16'h0000, 16'h8000, 16'h7fff};
    logic clk = 1'b0, rst = 1'b1, vld = 1'b0, flip = 1'b0;
    logic sclk, cs_n, mosi, miso, rdy;
    logic [3:0] code = 4'h0;
    logic [23:0] data = 24'h00_0000, rms = 24'h00_0000, amp = 24'h00_0000;
    logic [23:0] w [4];
    int fails = 0, checks = 0;
    initial forever #12.5 clk = ~clk;
    wcp_host i_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    wcp_top #(.SAMPLE_CYCLES(16)) i_dut (.CLK_SYS(clk), .RST(rst), .SPI_SCLK(sclk),
        .SPI_CS_N(cs_n), .SPI_MOSI(mosi), .SPI_MISO(miso), .SAMPLE_VALID(vld),
        .SAMPLE_READY(rdy), .SAMPLE_CODE(code), .SAMPLE_DATA(data), .RMS_A(rms),
        .RMS_B(rms), .RMS_C(rms), .RMS_N(rms));
    // Sign flips on each take so the stream carries no DC
    always @(posedge clk) if (vld && rdy) flip <= ~flip;
    always @(negedge clk) data <= flip ? -amp : amp;
    function automatic logic [23:0] scaled(input logic [23:0] a, input logic [15:0] g);
        logic signed [41:0] p;
        p = $signed({18'd0, a});
        p = p + ((p * $signed(g)) >>> 16);
        return (p > 42'sd8388607) ? 24'h7f_ffff : p[23:0];
    endfunction
    function automatic logic [23:0] mag(input logic [23:0] v);
        return v[23] ? -v : v;
    endfunction
    task automatic chk(input string s, input logic [23:0] e, input logic [23:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_rng(input string s, input logic [23:0] e, input logic [23:0] g);
        checks++;
        if ((g >= e - (e >> 3) && {1'b0, g} <= {1'b0, e} + (e >> 3)) !== 1'b1) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [23:0] v);
        i_host.frame(OP_READ, a, 1, w);
        v = w[0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [23:0] v);
        w[0] = v;
        i_host.frame(OP_WRITE, a, 1, w);
    endtask
    task automatic rc(input string s, input logic [7:0] a, input logic [23:0] e);
        logic [23:0] v;
        rd(a, v);
        chk(s, e, v);
    endtask
    task automatic summarize();
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #2_000_000;
        chk("watchdog", 24'h00_0000, 24'h00_0001);
        summarize();
    end
    initial begin
        logic [23:0] v;
        v = $urandom(32'h1360);
        repeat (12) @(negedge clk);
        rst = 1'b0;
        rms = 24'($urandom_range(32'h00_ffff));
        w[0] = 24'h00_0000;
        w[1] = 24'h00_0000;
        i_host.frame(OP_READ, SEG_LO_ADDR, 2, w);
        chk("seg_lo", SEG_LO_RST, w[0]);
        chk("seg_hi", SEG_HI_RST, w[1]);
        for (int k = 0; k < NCH; k++) begin
            rc("wave", WAVE_ADDR[k], 24'h00_0000);
            rc("gain", GAIN_ADDR[k], 24'h00_0000);
            rc("ofs", OFS_ADDR[k], 24'h00_0000);
            rc("delay", PHCAL_ADDR[k], 24'h00_0000);
        end
        rc("watt", WATT_ADDR[1], 24'h00_0000);
        wr(WAVE_ADDR[0], 24'h12_3456);
        rc("wave_ro", WAVE_ADDR[0], 24'h00_0000);
        rc("unmapped", 8'h01, 24'h00_0000);
        amp = 24'h10_0000 + 24'($urandom_range(32'h0f_ffff));
        code = 4'h8;
        vld = 1'b1;
        repeat (200) @(negedge clk);
        rc("leak_drop", WAVE_ADDR[0], 24'h00_0000);
        // Leakage on, then half gain, then saturating gain
        for (int i = 0; i < 3; i++) begin
            vld = 1'b0;
            @(negedge clk);
            amp = (i == 2) ? 24'h60_0000 : 24'h10_0000 + 24'($urandom_range(32'h0f_ffff));
            code = (i == 0) ? 4'h8 : 4'h0;
            vld = 1'b1;
            wr(CFG1_ADDR, (i == 0) ? 24'h80_0000 : 24'h00_0000);
            wr(GAIN_ADDR[0], {8'h00, GAINS[i]});
            repeat (200) @(negedge clk);
            rd(WAVE_ADDR[0], v);
            chk_rng("wave_mag", scaled(amp, GAINS[i]), mag(v));
        end
        vld = 1'b0;
        for (int k = 0; k < NCH; k++) begin
            v = 24'($urandom);
            wr(OFS_ADDR[k], v);
            rc("ofs_rw", OFS_ADDR[k], {8'h00, v[15:0]});
            wr(GAIN_ADDR[k], ~v);
            rc("gain_rw", GAIN_ADDR[k], {8'h00, ~v[15:0]});
            wr(PHCAL_ADDR[k], v);
            rc("delay_rw", PHCAL_ADDR[k], v);
        end
        summarize();
    end
endmodule
